// ===== rtl/cscr_pkg.sv
/*
 * Shared constants for the control signal register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cscr_pkg;
    // Register offsets
    localparam logic [15:0] ADR_KEY_STATUS  = 16'h01c2;
    localparam logic [15:0] ADR_REMOTE      = 16'h01cc;
    localparam logic [15:0] ADR_SAFETY_SP   = 16'h01cd;
    localparam logic [15:0] ADR_EXT_SP      = 16'h01ce;
    localparam logic [15:0] ADR_ALT_OUT     = 16'h01cf;
    localparam logic [15:0] ADR_MANUAL      = 16'h01d0;
    localparam logic [15:0] ADR_OUT_OFF     = 16'h01d1;
    localparam logic [15:0] ADR_RELAY_RST   = 16'h01d2;
    localparam logic [15:0] ADR_PROGRAM_RUN_CTRL_RUN    = 16'h01d3;
    localparam logic [15:0] ADR_ERR_RST     = 16'h01d6;
    localparam logic [15:0] ADR_PV_SEL      = 16'h01d7;
    localparam logic [15:0] ADR_IN_FORCE    = 16'h01e0;
    // Field positions
    localparam int unsigned DI1_BIT       = 0;
    localparam int unsigned KEY_ENTER_BIT = 8;
    localparam int unsigned KEY_DOWN_BIT  = 9;
    localparam int unsigned KEY_UP_BIT    = 10;
    localparam int unsigned FORCE_EN_BIT  = 0;
    localparam int unsigned FORCE_VAL_BIT = 8;
    // Values after reset and program step position limit
    localparam logic        CTRL_RST  = 1'b0;
    localparam logic [15:0] WORD_RST  = 16'h0000;
    localparam logic [15:0] POS_MAX   = 16'hffff;
    // Programmer states
    typedef enum logic [1:0] {
        CSCR_PG_IDLE = 2'b00,
        CSCR_PG_RUN  = 2'b01,
        CSCR_PG_HALT = 2'b10
    } cscr_pg_state_t;
endpackage : cscr_pkg

// ===== rtl/cscr_program_run_ctrl_if.sv
/*
 * Link between the register bank and its programmer sequencer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface cscr_program_run_ctrl_if;
    logic        run;
    logic        multi;
    logic        step;
    logic [15:0] pos;
    logic        running;
    modport ctrl (output run, multi, step, input  pos, running);
    modport program_run_ctrl (input  run, multi, step, output pos, running);
endinterface : cscr_program_run_ctrl_if
`default_nettype wire

// ===== rtl/cscr_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs asynchronous to i_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module cscr_sync
    import cscr_pkg::*;
#(
    parameter int unsigned W = 4
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    // Data
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;

    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            o_q  <= '0;
        end else begin
            s1_q <= i_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            o_q  <= (s3_q & agree) | (o_q & ~agree);
        end
    end
endmodule : cscr_sync
`default_nettype wire

// ===== rtl/cscr_program_run_ctrl.sv
/*
 * Programmer sequencer: start, stop, reset or hold of the program step.
 * Assumes run, multi and step come from logic on i_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module cscr_program_run_ctrl
    import cscr_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // Control link
    cscr_program_run_ctrl_if.program_run_ctrl p
);
    cscr_pg_state_t state_q;
    logic           run_prev_q;
    logic [15:0]    pos_q;
    logic           start;
    logic           stop;

    assign start     = p.run & ~run_prev_q;
    assign stop      = ~p.run & run_prev_q;
    assign p.pos     = pos_q;
    assign p.running = (state_q == CSCR_PG_RUN);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            run_prev_q <= CTRL_RST;
        end else begin
            run_prev_q <= p.run;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= CSCR_PG_IDLE;
            pos_q   <= WORD_RST;
        end else begin
            unique case (state_q)
                CSCR_PG_IDLE: begin
                    if (start) begin
                        state_q <= CSCR_PG_RUN;
                        pos_q   <= WORD_RST;
                    end
                end
                CSCR_PG_RUN: begin
                    if (stop && p.multi) begin
                        state_q <= CSCR_PG_HALT;
                    end else if (stop) begin
                        state_q <= CSCR_PG_IDLE;
                        pos_q   <= WORD_RST;
                    end else if (p.step && pos_q != POS_MAX) begin
                        pos_q <= pos_q + 16'h0001;
                    end
                end
                CSCR_PG_HALT: begin
                    if (start) begin
                        state_q <= CSCR_PG_RUN;
                    end
                end
                default: begin
                    state_q <= CSCR_PG_IDLE;
                end
            endcase
        end
    end

    sequence s_run_stop;
        state_q == CSCR_PG_RUN && stop;
    endsequence

    a_single_stop_rst:
        assert property (@(posedge i_clk) disable iff (i_srst)
            s_run_stop and !p.multi |=>
                state_q == CSCR_PG_IDLE && pos_q == WORD_RST)
        else $error("single program stop did not reset");

    a_multi_stop_hold:
        assert property (@(posedge i_clk) disable iff (i_srst)
            s_run_stop and p.multi |=>
                state_q == CSCR_PG_HALT && pos_q == $past(pos_q))
        else $error("multi program stop did not hold position");

    a_multi_resume:
        assert property (@(posedge i_clk) disable iff (i_srst)
            state_q == CSCR_PG_HALT && start |=>
                state_q == CSCR_PG_RUN && $stable(pos_q))
        else $error("halted program did not continue");
endmodule : cscr_program_run_ctrl
`default_nettype wire

// ===== rtl/cscr_top.sv
/*
 * Control signal register bank of a process controller: single-bit
 * control registers, input/key status, setpoint, output and process
 * value selection, error list, relay alarm and programmer control.
 * Assumes the field bus framing logic presents decoded register
 * accesses on i_clk; key and input pins are asynchronous.
 */
// Behaviour
// - Bit 0 of input status shows the first digital input.
// - Bits 8, 9, 10 of input status show confirm, down, up keys.
// - In remote mode panel adjustments are blocked; bus only.
// - Safety setpoint signal makes the second setpoint active.
// - The safety setpoint is never clamped to setpoint limits.
// - External setpoint signal selects the external setpoint value.
// - Second output signal selects the fixed alternate output.
// - Manual signal puts the controller in manual mode.
// - Output disable signal switches all controller outputs off.
// - Forced outputs still win while disabled; alarms keep running.
// - Writing one to error reset acknowledges the whole error list.
// - Errors still present reappear at the next measurement.
// - Writing one to relay reset clears the relay alarm.
// - Single-program stop resets; next start runs from the beginning.
// - Multi-program stop halts; next start continues.
// - Forcing bit 0 replaces the first digital input with bus value.
// - Source select switches process value between first and second.
`timescale 1ns/100ps
`default_nettype none
module cscr_top
    import cscr_pkg::*;
#(
    parameter int unsigned ERR_W = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    // Register access from the field bus
    input  wire logic             i_reg_wr,
    input  wire logic             i_reg_rd,
    input  wire logic [15:0]      i_reg_addr,
    input  wire logic [15:0]      i_reg_wdata,
    output var  logic [15:0]      o_reg_rdata,
    output var  logic             o_reg_ack,
    output var  logic             o_reg_err,
    // Front panel adjustments
    input  wire logic             i_panel_wr,
    input  wire logic [15:0]      i_panel_addr,
    input  wire logic [15:0]      i_panel_wdata,
    output var  logic             o_panel_blocked,
    // Pins
    input  wire logic             i_di1,
    input  wire logic             i_key_enter,
    input  wire logic             i_key_down,
    input  wire logic             i_key_up,
    // Setpoint sources and limits
    input  wire logic [15:0]      i_sp_main,
    input  wire logic [15:0]      i_sp_safety,
    input  wire logic [15:0]      i_sp_ext,
    input  wire logic [15:0]      i_sp_lo,
    input  wire logic [15:0]      i_sp_hi,
    output var  logic [15:0]      o_setpoint,
    // Controller output path
    input  wire logic [15:0]      i_ctrl_out,
    input  wire logic [15:0]      i_alt_out,
    input  wire logic [15:0]      i_manual_out,
    input  wire logic             i_force_out_en,
    input  wire logic [15:0]      i_force_out_val,
    output var  logic [15:0]      o_out,
    output var  logic             o_manual,
    // Process value and alarm
    input  wire logic [15:0]      i_pv1,
    input  wire logic [15:0]      i_pv2,
    input  wire logic [15:0]      i_alarm_lim,
    output var  logic [15:0]      o_pv,
    output var  logic             o_alarm,
    output var  logic             o_di,
    // Error list and relay alarm
    input  wire logic             i_meas_tick,
    input  wire logic [ERR_W-1:0] i_err_cause,
    input  wire logic             i_relay_fault,
    output var  logic [ERR_W-1:0] o_err_list,
    output var  logic             o_relay_alarm,
    // Programmer
    input  wire logic             i_program_run_ctrl_multi,
    input  wire logic             i_program_run_ctrl_step,
    output var  logic             o_program_run_ctrl_running,
    output var  logic [15:0]      o_program_run_ctrl_pos
);
    logic        remote_q;
    logic        safety_q;
    logic        ext_q;
    logic        alt_q;
    logic        manual_q;
    logic        off_q;
    logic        relay_rst_q;
    logic        program_run_ctrl_q;
    logic        err_rst_q;
    logic        pv_sel_q;
    logic        force_en_q;
    logic        force_val_q;
    logic [3:0]  pins_s;
    logic        panel_ok;
    logic        w_en;
    logic [15:0] w_addr;
    logic [15:0] w_data;
    logic        err_ack;
    logic        relay_ack;
    logic        di_eff;
    logic [15:0] status;
    logic [15:0] rd_word;
    logic        rd_hit;

    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : clamp

    cscr_sync #(
        .W (4)
    ) u_sync (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_d    ({i_key_up, i_key_down, i_key_enter, i_di1}),
        .o_q    (pins_s)
    );

    cscr_program_run_ctrl_if program_run_ctrl_link ();

    assign program_run_ctrl_link.run   = program_run_ctrl_q;
    assign program_run_ctrl_link.multi = i_program_run_ctrl_multi;
    assign program_run_ctrl_link.step  = i_program_run_ctrl_step;

    cscr_program_run_ctrl u_program_run_ctrl (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .p      (program_run_ctrl_link.program_run_ctrl)
    );

    // Panel writes pass only outside remote mode; bus wins a clash
    assign panel_ok = i_panel_wr & ~remote_q;
    assign w_en     = i_reg_wr | panel_ok;
    assign w_addr   = i_reg_wr ? i_reg_addr : i_panel_addr;
    assign w_data   = i_reg_wr ? i_reg_wdata : i_panel_wdata;
    assign err_ack  = w_en && w_addr == ADR_ERR_RST && w_data[0];
    assign relay_ack = w_en && w_addr == ADR_RELAY_RST && w_data[0];

    assign di_eff = force_en_q ? force_val_q : pins_s[0];

    always_comb begin
        status                = WORD_RST;
        status[DI1_BIT]       = di_eff;
        status[KEY_ENTER_BIT] = pins_s[1];
        status[KEY_DOWN_BIT]  = pins_s[2];
        status[KEY_UP_BIT]    = pins_s[3];
    end

    // Control bits keep bit 0 only; the input force register keeps bits 0 and 8
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            remote_q    <= CTRL_RST;
            safety_q    <= CTRL_RST;
            ext_q       <= CTRL_RST;
            alt_q       <= CTRL_RST;
            manual_q    <= CTRL_RST;
            off_q       <= CTRL_RST;
            relay_rst_q <= CTRL_RST;
            program_run_ctrl_q      <= CTRL_RST;
            err_rst_q   <= CTRL_RST;
            pv_sel_q    <= CTRL_RST;
            force_en_q  <= CTRL_RST;
            force_val_q <= CTRL_RST;
        end else if (w_en) begin
            unique case (w_addr)
                ADR_REMOTE:    remote_q    <= w_data[0];
                ADR_SAFETY_SP: safety_q    <= w_data[0];
                ADR_EXT_SP:    ext_q       <= w_data[0];
                ADR_ALT_OUT:   alt_q       <= w_data[0];
                ADR_MANUAL:    manual_q    <= w_data[0];
                ADR_OUT_OFF:   off_q       <= w_data[0];
                ADR_RELAY_RST: relay_rst_q <= w_data[0];
                ADR_PROGRAM_RUN_CTRL_RUN:  program_run_ctrl_q      <= w_data[0];
                ADR_ERR_RST:   err_rst_q   <= w_data[0];
                ADR_PV_SEL:    pv_sel_q    <= w_data[0];
                ADR_IN_FORCE: begin
                    force_en_q  <= w_data[FORCE_EN_BIT];
                    force_val_q <= w_data[FORCE_VAL_BIT];
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = WORD_RST;
        unique case (i_reg_addr)
            ADR_KEY_STATUS: rd_word = status;
            ADR_REMOTE:     rd_word[0] = remote_q;
            ADR_SAFETY_SP:  rd_word[0] = safety_q;
            ADR_EXT_SP:     rd_word[0] = ext_q;
            ADR_ALT_OUT:    rd_word[0] = alt_q;
            ADR_MANUAL:     rd_word[0] = manual_q;
            ADR_OUT_OFF:    rd_word[0] = off_q;
            ADR_RELAY_RST:  rd_word[0] = relay_rst_q;
            ADR_PROGRAM_RUN_CTRL_RUN:   rd_word[0] = program_run_ctrl_q;
            ADR_ERR_RST:    rd_word[0] = err_rst_q;
            ADR_PV_SEL:     rd_word[0] = pv_sel_q;
            ADR_IN_FORCE: begin
                rd_word[FORCE_EN_BIT]  = force_en_q;
                rd_word[FORCE_VAL_BIT] = force_val_q;
            end
            default:        rd_hit = 1'b0;
        endcase
    end

    // Bus answer one cycle after the request
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_reg_ack   <= CTRL_RST;
            o_reg_err   <= CTRL_RST;
            o_reg_rdata <= WORD_RST;
        end else begin
            o_reg_ack   <= i_reg_rd | i_reg_wr;
            o_reg_err   <= (i_reg_rd | i_reg_wr) &
                           (~rd_hit | (i_reg_wr &
                            i_reg_addr == ADR_KEY_STATUS));
            o_reg_rdata <= (i_reg_rd && rd_hit) ? rd_word : WORD_RST;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_panel_blocked <= CTRL_RST;
        end else begin
            o_panel_blocked <= i_panel_wr & remote_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_setpoint <= WORD_RST;
        end else if (safety_q) begin
            o_setpoint <= i_sp_safety;
        end else if (ext_q) begin
            o_setpoint <= clamp(i_sp_ext, i_sp_lo, i_sp_hi);
        end else begin
            o_setpoint <= clamp(i_sp_main, i_sp_lo, i_sp_hi);
        end
    end

    // Forcing above disable above manual above alternate
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_out    <= WORD_RST;
            o_manual <= CTRL_RST;
        end else begin
            o_manual <= manual_q;
            if (i_force_out_en) begin
                o_out <= i_force_out_val;
            end else if (off_q) begin
                o_out <= WORD_RST;
            end else if (manual_q) begin
                o_out <= i_manual_out;
            end else if (alt_q) begin
                o_out <= i_alt_out;
            end else begin
                o_out <= i_ctrl_out;
            end
        end
    end

    // Alarm check ignores output disable
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pv    <= WORD_RST;
            o_alarm <= CTRL_RST;
            o_di    <= CTRL_RST;
        end else begin
            o_pv    <= pv_sel_q ? i_pv2 : i_pv1;
            o_alarm <= o_pv > i_alarm_lim;
            o_di    <= di_eff;
        end
    end

    // Measurement entries win over a same-cycle acknowledge
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_err_list <= '0;
        end else begin
            o_err_list <= (err_ack ? '0 : o_err_list) |
                          (i_meas_tick ? i_err_cause : '0);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_relay_alarm <= CTRL_RST;
        end else if (i_relay_fault) begin
            o_relay_alarm <= 1'b1;
        end else if (relay_ack) begin
            o_relay_alarm <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_program_run_ctrl_running <= CTRL_RST;
            o_program_run_ctrl_pos     <= WORD_RST;
        end else begin
            o_program_run_ctrl_running <= program_run_ctrl_link.running;
            o_program_run_ctrl_pos     <= program_run_ctrl_link.pos;
        end
    end

    sequence s_err_ack_only;
        err_ack && !i_meas_tick;
    endsequence

    sequence s_err_ack_meas;
        err_ack && i_meas_tick;
    endsequence

    a_panel_blocked:
        assert property (@(posedge i_clk) disable iff (i_srst)
            remote_q && i_panel_wr && !i_reg_wr |=>
                o_panel_blocked && manual_q == $past(manual_q)
                && safety_q == $past(safety_q) && off_q == $past(off_q))
        else $error("panel write changed state in remote mode");

    a_safety_unclamped:
        assert property (@(posedge i_clk) disable iff (i_srst)
            safety_q |=> o_setpoint == $past(i_sp_safety))
        else $error("safety setpoint not passed unclamped");

    a_ext_setpoint:
        assert property (@(posedge i_clk) disable iff (i_srst)
            !safety_q && ext_q |=>
                o_setpoint == clamp($past(i_sp_ext), $past(i_sp_lo),
                                    $past(i_sp_hi)))
        else $error("external setpoint not selected");

    a_alt_output:
        assert property (@(posedge i_clk) disable iff (i_srst)
            alt_q && !manual_q && !off_q && !i_force_out_en |=>
                o_out == $past(i_alt_out))
        else $error("alternate output not selected");

    a_disable_zero:
        assert property (@(posedge i_clk) disable iff (i_srst)
            off_q && !i_force_out_en |=> o_out == WORD_RST)
        else $error("disabled output not zero");

    a_force_wins:
        assert property (@(posedge i_clk) disable iff (i_srst)
            i_force_out_en |=> o_out == $past(i_force_out_val))
        else $error("forced output lost");

    a_err_ack_clear:
        assert property (@(posedge i_clk) disable iff (i_srst)
            s_err_ack_only |=> o_err_list == '0)
        else $error("error list not cleared");

    a_err_reenter:
        assert property (@(posedge i_clk) disable iff (i_srst)
            s_err_ack_meas |=> o_err_list == $past(i_err_cause))
        else $error("present error not entered again");

    a_relay_clear:
        assert property (@(posedge i_clk) disable iff (i_srst)
            relay_ack && !i_relay_fault |=> !o_relay_alarm)
        else $error("relay alarm not cleared");

    a_di_forced:
        assert property (@(posedge i_clk) disable iff (i_srst)
            force_en_q |=> o_di == $past(force_val_q))
        else $error("forced input not used");

    a_pv_select:
        assert property (@(posedge i_clk) disable iff (i_srst)
            pv_sel_q |=> o_pv == $past(i_pv2))
        else $error("second process value not selected");
endmodule : cscr_top
`default_nettype wire

// ===== bench/cscr_master.sv
/* Field bus master model: one-cycle register access strobes.
   Assumes callers enter just after a rising edge of i_clk. */
`timescale 1ns/100ps
`default_nettype none
module cscr_master
    import cscr_pkg::*;
(
    // Clock
    input  wire logic        i_clk,
    // Register access
    output var  logic        o_wr,
    output var  logic        o_rd,
    output var  logic [15:0] o_addr,
    output var  logic [15:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 16'h0000;
    end
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [15:0] d);
        o_wr = w;
        o_rd = !w;
        o_addr = a;
        o_wdata = (a == ADR_IN_FORCE) ? d : {15'h0000, d[0]};
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_rd = 1'b0;
        // Released bus shows inverted data
        o_wdata = ~o_wdata;
        // Idle edge keeps back-to-back strobes apart
        @(posedge i_clk);
        #1;
    endtask : acc
endmodule : cscr_master
`default_nettype wire

// ===== bench/cscr_bench.sv
/* Self-checking bench of the control signal register bank.
   Assumes the bus master model drives all register accesses. */
`timescale 1ns/100ps
`default_nettype none
module cscr_bench
    import cscr_pkg::*;
;
    logic i_clk, i_srst, i_reg_wr, i_reg_rd, i_panel_wr, i_di1, i_key_enter,
          i_key_down, i_key_up, i_force_out_en, i_meas_tick, i_relay_fault,
          i_program_run_ctrl_multi, i_program_run_ctrl_step, o_reg_ack, o_reg_err, o_panel_blocked,
          o_manual, o_alarm, o_di, o_relay_alarm, o_program_run_ctrl_running;
    logic [15:0] i_reg_addr, i_reg_wdata, i_panel_addr, i_panel_wdata,
          i_sp_main, i_sp_safety, i_sp_ext, i_sp_lo, i_sp_hi, i_ctrl_out,
          i_alt_out, i_manual_out, i_force_out_val, i_pv1, i_pv2,
          i_alarm_lim, o_reg_rdata, o_setpoint, o_out, o_pv, o_program_run_ctrl_pos;
    logic [7:0]  i_err_cause, o_err_list;
    logic [17:0] q[$];
    logic [17:0] e;
    logic [15:0] r, hold;
    logic [31:0] seed = 32'd69610;
    logic [15:0] regs[10] = '{ADR_REMOTE, ADR_SAFETY_SP, ADR_EXT_SP,
          ADR_ALT_OUT, ADR_MANUAL, ADR_OUT_OFF, ADR_RELAY_RST, ADR_PROGRAM_RUN_CTRL_RUN,
          ADR_ERR_RST, ADR_PV_SEL};
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    cscr_top dut (.*);
    cscr_master m (.i_clk(i_clk), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
                   .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    function logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen,
                     exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, d, input logic er);
        q.push_back({1'b0, er, 16'h0000});
        m.acc(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [15:0] a, d, input logic er);
        q.push_back({1'b1, er, d});
        m.acc(1'b0, a, 16'h0000);
    endtask : rd
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    always @(negedge i_clk) begin
        if (o_reg_ack === 1'b1) begin
            if (q.size() == 0)
                chk(16'h0001, 16'h0000);
            else begin
                e = q.pop_front();
                chk({15'h0000, o_reg_err}, {15'h0000, e[16]});
                if (e[17])
                    chk(o_reg_rdata, e[15:0]);
            end
        end
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        {i_srst, i_panel_wr, i_di1, i_key_enter, i_key_down, i_key_up,
         i_force_out_en, i_meas_tick, i_relay_fault, i_program_run_ctrl_multi,
         i_program_run_ctrl_step, i_err_cause} = '0;
        {i_panel_addr, i_panel_wdata, i_sp_main, i_sp_safety, i_sp_ext,
         i_ctrl_out, i_alt_out, i_manual_out, i_force_out_val, i_pv1, i_pv2,
         i_alarm_lim} = '0;
        i_sp_lo = 16'h1000;
        i_sp_hi = 16'h2000;
        i_srst = 1'b1;
        cyc(10);
        i_srst = 1'b0;
        foreach (regs[k]) rd(regs[k], WORD_RST, 1'b0);
        foreach (regs[k]) wr(regs[k], 16'h0001, 1'b0);
        foreach (regs[k]) rd(regs[k], 16'h0001, 1'b0);
        foreach (regs[k]) wr(regs[k], 16'h0000, 1'b0);
        rd(16'h01c3, 16'h0000, 1'b1);
        wr(ADR_KEY_STATUS, 16'h0001, 1'b1);
        r = rnd();
        {i_key_up, i_key_down, i_key_enter, i_di1} = r[3:0];
        cyc(6);
        rd(ADR_KEY_STATUS, {5'h00, r[3:1], 7'h00, r[0]}, 1'b0);
        chk({15'h0000, o_di}, {15'h0000, r[0]});
        wr(ADR_IN_FORCE, {7'h00, ~r[0], 8'h01}, 1'b0);
        cyc(2);
        chk({15'h0000, o_di}, {15'h0000, ~r[0]});
        rd(ADR_KEY_STATUS, {5'h00, r[3:1], 7'h00, ~r[0]}, 1'b0);
        wr(ADR_IN_FORCE, 16'h0000, 1'b0);
        {i_ctrl_out, i_alt_out, i_manual_out} = {rnd(), rnd(), rnd()};
        {i_force_out_val, i_pv2} = {rnd(), rnd()};
        for (int p = 1; p >= 0; p--) begin
            wr(ADR_REMOTE, 16'(p), 1'b0);
            {i_panel_wr, i_panel_addr, i_panel_wdata} = {1'b1, ADR_MANUAL,
                                                         16'h0001};
            cyc(1);
            i_panel_wr = 1'b0;
            chk({15'h0000, o_panel_blocked}, 16'(p));
            cyc(2);
            chk({15'h0000, o_manual}, 16'(1 - p));
        end
        chk(o_out, i_manual_out);
        wr(ADR_MANUAL, 16'h0000, 1'b0);
        wr(ADR_ALT_OUT, 16'h0001, 1'b0);
        cyc(2);
        chk(o_out, i_alt_out);
        wr(ADR_OUT_OFF, 16'h0001, 1'b0);
        {i_pv1, i_alarm_lim} = {16'h8000, 16'h0010};
        cyc(2);
        chk(o_out, 16'h0000);
        chk({15'h0000, o_alarm}, 16'h0001);
        i_force_out_en = 1'b1;
        cyc(2);
        chk(o_out, i_force_out_val);
        i_force_out_en = 1'b0;
        wr(ADR_PV_SEL, 16'h0001, 1'b0);
        cyc(2);
        chk(o_pv, i_pv2);
        {i_sp_main, i_sp_ext, i_sp_safety} = {16'h1800, 16'h3000,
                                              rnd() | 16'h8000};
        wr(ADR_EXT_SP, 16'h0001, 1'b0);
        cyc(2);
        chk(o_setpoint, 16'h2000);
        wr(ADR_SAFETY_SP, 16'h0001, 1'b0);
        cyc(2);
        chk(o_setpoint, i_sp_safety);
        {i_err_cause, i_meas_tick} = {8'h5a, 1'b1};
        cyc(1);
        {i_err_cause, i_meas_tick} = {8'h02, 1'b0};
        cyc(2);
        chk({8'h00, o_err_list}, 16'h005a);
        wr(ADR_ERR_RST, 16'h0001, 1'b0);
        cyc(2);
        chk({8'h00, o_err_list}, 16'h0000);
        i_meas_tick = 1'b1;
        cyc(1);
        i_meas_tick = 1'b0;
        cyc(2);
        chk({8'h00, o_err_list}, 16'h0002);
        {i_err_cause, i_meas_tick} = {8'h81, 1'b1};
        wr(ADR_ERR_RST, 16'h0001, 1'b0);
        i_meas_tick = 1'b0;
        cyc(2);
        chk({8'h00, o_err_list}, 16'h0081);
        i_relay_fault = 1'b1;
        cyc(1);
        i_relay_fault = 1'b0;
        cyc(2);
        chk({15'h0000, o_relay_alarm}, 16'h0001);
        wr(ADR_RELAY_RST, 16'h0001, 1'b0);
        cyc(2);
        chk({15'h0000, o_relay_alarm}, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            i_program_run_ctrl_multi = p[0];
            wr(ADR_PROGRAM_RUN_CTRL_RUN, 16'h0001, 1'b0);
            repeat (3) begin
                i_program_run_ctrl_step = 1'b1;
                cyc(1);
                i_program_run_ctrl_step = 1'b0;
                cyc(1);
            end
            cyc(3);
            chk(o_program_run_ctrl_pos, 16'h0003);
            hold = p ? 16'h0003 : 16'h0000;
            wr(ADR_PROGRAM_RUN_CTRL_RUN, 16'h0000, 1'b0);
            cyc(3);
            chk(o_program_run_ctrl_pos, hold);
            wr(ADR_PROGRAM_RUN_CTRL_RUN, 16'h0001, 1'b0);
            cyc(3);
            chk({15'h0000, o_program_run_ctrl_running}, 16'h0001);
            chk(o_program_run_ctrl_pos, hold);
            wr(ADR_PROGRAM_RUN_CTRL_RUN, 16'h0000, 1'b0);
        end
        cyc(4);
        results();
    end
endmodule : cscr_bench
`default_nettype wire
